// ### pkg/mic_pkg.sv
// Package for the interrupt controller: register map, timing and carrier types
package mic_pkg;
  // APB register offsets (byte addresses)
  localparam logic [7:0] MIC_OPT_OFF = 8'hC8;
  localparam logic [7:0] MIC_STAT_OFF = 8'hCC;
  localparam logic [7:0] MIC_PER_EN_OFF = 8'hD0;
  // Option register fields
  localparam int MIC_LES_BIT = 6;
  localparam int MIC_ESB_BIT = 5;
  localparam int MIC_GEN_BIT = 4;
  localparam logic [7:0] MIC_OPT_RST = 8'h00;
  localparam logic [7:0] MIC_OPT_WMASK = 8'h70;
  // Vector addresses in program space
  localparam logic [11:0] MIC_VEC_NMI = 12'hFFC;
  localparam logic [11:0] MIC_VEC_1 = 12'hFF6;
  localparam logic [11:0] MIC_VEC_2 = 12'hFF4;
  localparam logic [11:0] MIC_VEC_3 = 12'hFF2;
  localparam logic [11:0] MIC_VEC_4 = 12'hFF0;
  // Response time in CPU cycles, each CPU cycle 13 clocks
  localparam int MIC_CPU_CYC_CLKS = 13;
  localparam int MIC_RESP_MIN_CPU = 6;
  localparam int MIC_RESP_MAX_CPU = 11;
  localparam int MIC_RESP_MIN_CLKS = MIC_RESP_MIN_CPU * MIC_CPU_CYC_CLKS;
  localparam int MIC_RESP_MAX_CLKS = MIC_RESP_MAX_CPU * MIC_CPU_CYC_CLKS;
  localparam int MIC_LDI_EARLY_CYC = 3;
  // Core mode
  typedef enum logic [1:0] {MIC_MODE_NORMAL, MIC_MODE_IRQ, MIC_MODE_NMI} mic_mode_t;
  // Grant handed to the core
  typedef struct packed {
    logic valid;
    logic [2:0] vec_num;
    logic [11:0] vec_addr;
  } mic_grant_t;
endpackage : mic_pkg

// ### verilog/mic_ctrl.sv
// Interrupt controller: latching, gating, priority, mode tracking and wake-up
// Function
// - Four maskable sources plus one non-maskable, each with a fixed vector address.
// - Maskable service only while global enable set; events latched meanwhile.
// - Reset pre-empts any service routine, non-maskable or maskable.
// - Non-maskable is top priority, pre-empts maskable, never itself.
// - Maskable routines never nest; vector 1 highest, vector 4 lowest.
// - Any source wakes from WAIT; only pins and designated peripherals from STOP.
// - Falling edge on non-maskable pin raises request regardless of global enable.
// - Non-maskable request held in a flip-flop cleared on its routine entry.
// - Peripheral flag requests only when global and own enable are set.
// - Peripherals map to vectors 3 and 4, ORed; flags held until software clears.
// - Pin requests on vectors 1 and 2, loaded only with global enable set.
// - Vector 1 selectable between edge and low-level triggering.
// - Vector 2 always edge triggered with selectable polarity.
// - Edge latch sets on edge, clears at routine start; extra edges dropped.
// - Switching vector 2 to rising polarity latches one spurious request.
// - One vector 2 pin held at its active level blocks edges of others.
// - Reconfiguring a low vector 2 pin latches a spurious request.
// - Entry swaps flags, pushes PC, inhibits maskable, clears latch, loads vector.
// - Return-from-interrupt instruction resumes the interrupted routine.
// - Request in first 3 cycles of option clear keeps normal carry/zero flags.
// - Response latency is 6 to 11 CPU cycles of 13 clocks each.
// - Level/edge select 0 gives falling edge, 1 gives low level.
// - Edge polarity 0 gives falling edge, 1 gives rising edge.
// - Global enable is bit 4 of option register at C8, reset zero.
// - With global enable clear, non-maskable is serviced but cannot wake.
`timescale 1ns/1ps
`default_nettype none
module mic_ctrl
  import mic_pkg::*;
#(
  parameter int VEC2_PINS = 8
) (
  input wire logic ref_clk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic nmi_pin_n, // Non-maskable request pin, falling edge
  input wire logic vec1_pin, // Vector 1 external pin
  input wire logic [VEC2_PINS-1:0] vec2_pins, // Vector 2 external pins
  input wire logic [VEC2_PINS-1:0] vec2_irq_en, // Pin configured as interrupt input
  input wire logic [1:0] per_flags, // Peripheral flags for vectors 3 and 4
  input wire logic instr_boundary, // Core at an instruction boundary
  input wire logic entry_ack, // Core begins the granted entry
  input wire logic return_from_irq, // Core executes return from interrupt
  input wire logic opt_clear_early, // Option-clear load within its first cycles
  input wire logic in_stop, // Core is in STOP
  input wire logic in_wait, // Core is in WAIT
  output mic_pkg::mic_grant_t grant, // Request to load a vector
  output mic_pkg::mic_mode_t core_mode, // Current core mode
  output logic keep_normal_flags, // Keep normal carry/zero at entry
  output logic wake // Wake the core from a low-power mode
);
  import mic_pkg::*;

  // Register state
  logic [7:0] opt_r;
  logic [1:0] per_en_r;
  logic nmi_q_r, nmi_lat_r, v1_q_r, v1_lat_r, v2_q_r, v2_lat_r, esb_q_r;
  logic [VEC2_PINS-1:0] v2_en_q_r;
  mic_mode_t mode_r, mode_nxt;
  mic_mode_t prev_mode_r;
  mic_grant_t grant_r, grant_nxt;
  logic keep_r;
  logic [31:0] prdata_r;
  logic [7:0] grant_wait_r;

  // Option field decode
  wire gen = opt_r[MIC_GEN_BIT];
  wire vec1_level_edge_select = opt_r[MIC_LES_BIT];
  wire vec2_edge_polarity = opt_r[MIC_ESB_BIT];

  // APB decode
  wire apb_acc = psel && penable;
  wire hit_opt = paddr == MIC_OPT_OFF;
  wire hit_stat = paddr == MIC_STAT_OFF;
  wire hit_per = paddr == MIC_PER_EN_OFF;
  wire wr_opt = apb_acc && pwrite && hit_opt;
  wire wr_per = apb_acc && pwrite && hit_per;
  wire mapped = hit_opt || hit_stat || hit_per;
  assign pready = 1'b1;
  assign pslverr = apb_acc && !mapped;

  // Vector 2 combined line: AND for falling, OR for rising, so one stuck pin masks others
  wire v2_and = &(vec2_pins | ~vec2_irq_en);
  wire v2_or = |(vec2_pins & vec2_irq_en);
  wire v2_line = vec2_edge_polarity ? v2_or : v2_and;
  // Spurious sets from polarity switch and reconfiguring a low pin
  wire v2_esb_rise = vec2_edge_polarity && !esb_q_r && (|vec2_irq_en);
  wire v2_cfg_spur = |((vec2_irq_en ^ v2_en_q_r) & ~vec2_pins);
  wire v2_edge = (vec2_edge_polarity ? (v2_line && !v2_q_r) : (!v2_line && v2_q_r)) && (vec2_edge_polarity == esb_q_r);

  // Edge detection and level requests
  wire nmi_edge = !nmi_pin_n && nmi_q_r;
  wire v1_edge = !vec1_pin && v1_q_r;
  wire v1_req = vec1_level_edge_select ? !vec1_pin : v1_lat_r;
  wire v2_req = v2_lat_r;
  wire [1:0] per_req = per_flags & per_en_r;

  // Maskable pending vector, gated by global enable, fixed priority
  wire [3:0] mpend = {per_req[1], per_req[0], v2_req, v1_req};
  wire mask_ok = gen && mode_r == MIC_MODE_NORMAL;
  wire take_nmi = nmi_lat_r && mode_r != MIC_MODE_NMI;
  wire take_mask = mask_ok && (|mpend);

  // Grant selection, only at instruction boundaries
  always_comb
  begin
    grant_nxt = grant_r;
    if (grant_r.valid && entry_ack)
    begin
      grant_nxt = '0;
    end
    else if (!grant_r.valid && instr_boundary)
    begin
      if (take_nmi)
      begin
        grant_nxt = '{1'b1, 3'd0, MIC_VEC_NMI};
      end
      else if (take_mask)
      begin
        if (mpend[0]) grant_nxt = '{1'b1, 3'd1, MIC_VEC_1};
        else if (mpend[1]) grant_nxt = '{1'b1, 3'd2, MIC_VEC_2};
        else if (mpend[2]) grant_nxt = '{1'b1, 3'd3, MIC_VEC_3};
        else grant_nxt = '{1'b1, 3'd4, MIC_VEC_4};
      end
    end
  end

  // Mode tracking: entry inhibits maskable, return restores
  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      MIC_MODE_NORMAL, MIC_MODE_IRQ:
      begin
        if (grant_r.valid && entry_ack)
          mode_nxt = grant_r.vec_num == 3'd0 ? MIC_MODE_NMI : MIC_MODE_IRQ;
        else if (return_from_irq && mode_r == MIC_MODE_IRQ)
          mode_nxt = MIC_MODE_NORMAL;
      end
      MIC_MODE_NMI:
      begin
        if (return_from_irq)
          mode_nxt = prev_mode_r;
      end
      default: mode_nxt = MIC_MODE_NMI;
    endcase
  end

  // Wake: any request from WAIT, pins and vector 3 from STOP; every source, nmi included, needs global enable
  wire nmi_wake = nmi_lat_r && gen;
  wire wake_wait = nmi_wake || (gen && (|mpend));
  wire wake_stop = nmi_wake || (gen && (v1_req || v2_req || per_req[0]));
  assign wake = (in_wait && wake_wait) || (in_stop && wake_stop);

  // Register and latch updates; set wins over clear
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      opt_r <= MIC_OPT_RST;
      per_en_r <= 2'b00;
      nmi_q_r <= 1'b1;
      nmi_lat_r <= 1'b0;
      v1_q_r <= 1'b1;
      v1_lat_r <= 1'b0;
      v2_q_r <= 1'b1;
      v2_lat_r <= 1'b0;
      esb_q_r <= 1'b0;
      v2_en_q_r <= '0;
      mode_r <= MIC_MODE_NMI;
      prev_mode_r <= MIC_MODE_NORMAL;
      grant_r <= '0;
      keep_r <= 1'b0;
    end
    else
    begin
      if (wr_opt) opt_r <= pwdata[7:0] & MIC_OPT_WMASK;
      if (wr_per) per_en_r <= pwdata[1:0];
      nmi_q_r <= nmi_pin_n;
      v1_q_r <= vec1_pin;
      v2_q_r <= v2_line;
      esb_q_r <= vec2_edge_polarity;
      v2_en_q_r <= vec2_irq_en;
      // set on edge, cleared at entry
      nmi_lat_r <= nmi_edge || (nmi_lat_r && !(entry_ack && grant_r.valid && grant_r.vec_num == 3'd0));
      // single pending edge, cleared at entry
      v1_lat_r <= (v1_edge && !vec1_level_edge_select) || (v1_lat_r && !vec1_level_edge_select && !(entry_ack && grant_r.valid && grant_r.vec_num == 3'd1));
      v2_lat_r <= v2_edge || v2_esb_rise || v2_cfg_spur
        || (v2_lat_r && !(entry_ack && grant_r.valid && grant_r.vec_num == 3'd2));
      grant_r <= grant_nxt;
      if (grant_r.valid && entry_ack && grant_r.vec_num == 3'd0) prev_mode_r <= mode_r;
      mode_r <= mode_nxt;
      // maskable entry during early option-clear keeps normal flags
      if (grant_r.valid && entry_ack)
        keep_r <= grant_r.vec_num != 3'd0 && opt_clear_early;
    end
  end

  // Read data: option register is write-only and reads zero
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      prdata_r <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata_r <= hit_stat ? {24'h0, 1'b0, mode_r == MIC_MODE_NMI, mode_r == MIC_MODE_IRQ, nmi_lat_r,
                              per_req[1], per_req[0], v2_lat_r, v1_req}
                : hit_per ? {30'h0, per_en_r} : 32'h0;
  end

  assign prdata = prdata_r;
  assign grant = grant_r;
  assign core_mode = mode_r;
  assign keep_normal_flags = keep_r;

  // Cycles a standing grant has waited for the core to start entry; saturates
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      grant_wait_r <= 8'h00;
    else if (!grant_r.valid)
      grant_wait_r <= 8'h00;
    else if (grant_wait_r != 8'hFF)
      grant_wait_r <= grant_wait_r + 8'h01;
  end

  // Checks
  property p_nmi_latch;
    @(posedge ref_clk) disable iff (!nrst) nmi_edge |=> nmi_lat_r;
  endproperty
  a_nmi_latch: assert property (p_nmi_latch) else $error("nmi edge not latched");
  property p_no_mask_gen;
    @(posedge ref_clk) disable iff (!nrst) (grant_nxt.valid && !grant_r.valid && grant_nxt.vec_num != 3'd0) |-> gen;
  endproperty
  a_no_mask_gen: assert property (p_no_mask_gen) else $error("maskable grant without enable");
  property p_no_nest;
    @(posedge ref_clk) disable iff (!nrst) (mode_r != MIC_MODE_NORMAL && !grant_r.valid) |=> !(grant_r.valid && grant_r.vec_num != 3'd0);
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("maskable nesting");
  property p_prio;
    @(posedge ref_clk) disable iff (!nrst) (!grant_r.valid && instr_boundary && take_nmi) |=> grant_r.vec_num == 3'd0;
  endproperty
  a_prio: assert property (p_prio) else $error("nmi not prioritised");
  property p_nmi_clear;
    @(posedge ref_clk) disable iff (!nrst) (grant_r.valid && entry_ack && grant_r.vec_num == 3'd0 && nmi_pin_n) |=> !nmi_lat_r && mode_r == MIC_MODE_NMI;
  endproperty
  a_nmi_clear: assert property (p_nmi_clear) else $error("nmi entry wrong");
  property p_v1_prio;
    @(posedge ref_clk) disable iff (!nrst) (!grant_r.valid && instr_boundary && !take_nmi && take_mask && mpend[0]) |=> grant_r.vec_addr == MIC_VEC_1;
  endproperty
  a_v1_prio: assert property (p_v1_prio) else $error("vector 1 not first");
  property p_nmi_wake;
    @(posedge ref_clk) disable iff (!nrst) !gen |-> !wake;
  endproperty
  a_nmi_wake: assert property (p_nmi_wake) else $error("woke without enable");
  property p_boundary;
    @(posedge ref_clk) disable iff (!nrst) (!grant_r.valid && !instr_boundary) |=> !grant_r.valid;
  endproperty
  a_boundary: assert property (p_boundary) else $error("grant off boundary");

  // Vector 2 spurious latching on polarity switch and pin reconfiguration
  property p_v2_spur_esb;
    @(posedge ref_clk) disable iff (!nrst) v2_esb_rise |=> v2_lat_r;
  endproperty
  a_v2_spur_esb: assert property (p_v2_spur_esb) else $error("polarity switch not latched");

  property p_v2_cfg;
    @(posedge ref_clk) disable iff (!nrst) v2_cfg_spur |=> v2_lat_r;
  endproperty
  a_v2_cfg: assert property (p_v2_cfg) else $error("reconfiguration not latched");

  // Edge latching on the pin vectors
  property p_v1_edge;
    @(posedge ref_clk) disable iff (!nrst) (v1_edge && !vec1_level_edge_select) |=> v1_lat_r;
  endproperty
  a_v1_edge: assert property (p_v1_edge) else $error("vector 1 edge not latched");

  property p_v2_edge;
    @(posedge ref_clk) disable iff (!nrst) v2_edge |=> v2_lat_r;
  endproperty
  a_v2_edge: assert property (p_v2_edge) else $error("vector 2 edge not latched");

  // Level mode stores nothing
  property p_v1_level;
    @(posedge ref_clk) disable iff (!nrst) vec1_level_edge_select |=> !v1_lat_r;
  endproperty
  a_v1_level: assert property (p_v1_level) else $error("level mode stored a request");

  // Latches clear when their routine starts
  property p_v1_clear;
    @(posedge ref_clk) disable iff (!nrst)
      (grant_r.valid && entry_ack && grant_r.vec_num == 3'd1 && !v1_edge) |=> !v1_lat_r;
  endproperty
  a_v1_clear: assert property (p_v1_clear) else $error("vector 1 latch not cleared");

  property p_v2_clear;
    @(posedge ref_clk) disable iff (!nrst)
      (grant_r.valid && entry_ack && grant_r.vec_num == 3'd2 && !v2_edge && !v2_esb_rise && !v2_cfg_spur)
      |=> !v2_lat_r;
  endproperty
  a_v2_clear: assert property (p_v2_clear) else $error("vector 2 latch not cleared");

  // Peripheral grants need the flag, its own enable and the global enable
  property p_per3_gate;
    @(posedge ref_clk) disable iff (!nrst)
      (grant_nxt.valid && !grant_r.valid && grant_nxt.vec_num == 3'd3) |-> gen && per_flags[0] && per_en_r[0];
  endproperty
  a_per3_gate: assert property (p_per3_gate) else $error("vector 3 granted without enables");

  property p_per4_gate;
    @(posedge ref_clk) disable iff (!nrst)
      (grant_nxt.valid && !grant_r.valid && grant_nxt.vec_num == 3'd4) |-> gen && per_flags[1] && per_en_r[1];
  endproperty
  a_per4_gate: assert property (p_per4_gate) else $error("vector 4 granted without enables");

  // Pin vectors load only with global enable
  property p_pin_gen;
    @(posedge ref_clk) disable iff (!nrst)
      (grant_nxt.valid && !grant_r.valid && (grant_nxt.vec_num == 3'd1 || grant_nxt.vec_num == 3'd2)) |-> gen;
  endproperty
  a_pin_gen: assert property (p_pin_gen) else $error("pin vector without enable");

  // Maskable entry inhibits further maskable requests
  property p_entry_mode;
    @(posedge ref_clk) disable iff (!nrst)
      (grant_r.valid && entry_ack && grant_r.vec_num != 3'd0) |=> mode_r == MIC_MODE_IRQ && !grant_r.valid;
  endproperty
  a_entry_mode: assert property (p_entry_mode) else $error("maskable entry wrong");

  // Return from a maskable routine resumes normal mode
  property p_ret_irq;
    @(posedge ref_clk) disable iff (!nrst)
      (mode_r == MIC_MODE_IRQ && return_from_irq && !(grant_r.valid && entry_ack)) |=> mode_r == MIC_MODE_NORMAL;
  endproperty
  a_ret_irq: assert property (p_ret_irq) else $error("return did not resume");

  // Reset clears latches and leaves the core in non-maskable mode
  property p_reset;
    @(posedge ref_clk) !nrst |=> mode_r == MIC_MODE_NMI && !nmi_lat_r && !grant_r.valid && !v2_lat_r;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  // Wake-up: any enabled request from WAIT, vector 4 alone never from STOP
  property p_wake_wait;
    @(posedge ref_clk) disable iff (!nrst) (in_wait && gen && (|mpend)) |-> wake;
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("no wake from wait");

  property p_stop_v4;
    @(posedge ref_clk) disable iff (!nrst)
      (in_stop && !in_wait && !nmi_lat_r && !v1_req && !v2_req && !per_req[0]) |-> !wake;
  endproperty
  a_stop_v4: assert property (p_stop_v4) else $error("vector 4 woke from stop");

  // Early option clear keeps the normal flags
  property p_keep;
    @(posedge ref_clk) disable iff (!nrst)
      (grant_r.valid && entry_ack && grant_r.vec_num != 3'd0 && opt_clear_early) |=> keep_r;
  endproperty
  a_keep: assert property (p_keep) else $error("normal flags not kept");

  // Global enable field follows the written word
  property p_gen_field;
    @(posedge ref_clk) disable iff (!nrst) wr_opt |=> gen == $past(pwdata[MIC_GEN_BIT]);
  endproperty
  a_gen_field: assert property (p_gen_field) else $error("global enable not written");

  // A standing grant is taken up within the response bound
  property p_resp;
    @(posedge ref_clk) disable iff (!nrst) grant_wait_r < MIC_RESP_MAX_CLKS;
  endproperty
  a_resp: assert property (p_resp) else $error("grant waited too long");
endmodule : mic_ctrl
`default_nettype wire

// ### tb/mic_core_model.sv
// Core-side partner model: instruction boundaries and vector entry
`timescale 1ns/1ps
`default_nettype none
module mic_core_model
  import mic_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [1:0] dly, // Extra wait before entry
  input wire mic_pkg::mic_grant_t grant, // Grant from controller
  output logic instr_boundary, // Boundary pulse
  output logic entry_ack // Entry start pulse
);
  logic [1:0] ph_r;
  logic [2:0] wt_r;
  // One boundary per four-cycle instruction
  always_ff @(posedge ref_clk)
  begin
    ph_r <= nrst ? ph_r + 2'h1 : 2'h0;
    instr_boundary <= nrst && ph_r == 2'h3;
  end
  // Begin entry of a standing grant after a slow or prompt wait
  always_ff @(posedge ref_clk)
  begin
    wt_r <= (grant.valid && !entry_ack) ? wt_r + 3'h1 : 3'h0;
    entry_ack <= nrst && grant.valid && !entry_ack && wt_r >= {1'b0, dly};
  end
endmodule : mic_core_model
`default_nettype wire

// ### tb/mic_ctrl_tb.sv
// Self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_ctrl_tb;
  import mic_pkg::*;
  logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, nmi_pin_n = 1, vec1_pin = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, keep, wake, ib, ack, ret = 0, oce = 0, stp = 0, wt = 0;
  logic [1:0] v2 = 2'h3, v2en = 2'h3, pf = 2'h0, dly = 2'h0;
  mic_grant_t grant;
  mic_mode_t core_mode;
  int error_cnt = 0, checks_done = 0, v = 0, pend[5] = '{0, 0, 0, 0, 0};
  logic [11:0] va[5] = '{MIC_VEC_NMI, MIC_VEC_1, MIC_VEC_2, MIC_VEC_3, MIC_VEC_4};
  always #50 ref_clk = ~ref_clk;
  mic_ctrl #(.VEC2_PINS(2)) DUT (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmi_pin_n(nmi_pin_n), .vec1_pin(vec1_pin), .vec2_pins(v2), .vec2_irq_en(v2en), .per_flags(pf),
    .instr_boundary(ib), .entry_ack(ack), .return_from_irq(ret), .opt_clear_early(oce), .in_stop(stp),
    .in_wait(wt), .grant(grant), .core_mode(core_mode), .keep_normal_flags(keep), .wake(wake));
  mic_core_model CORE (.ref_clk(ref_clk), .nrst(nrst), .dly(dly), .grant(grant), .instr_boundary(ib),
    .entry_ack(ack));
  task results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  // APB master: setup, access, hold until pready sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Model: highest priority pending source the mode allows
  function automatic int pick(input int md, input int gen);
    for (int i = 0; i < 5; i++)
      if (pend[i] != 0 && (i == 0 ? md != 2 : (md == 0 && gen != 0)))
        return i;
    return -1;
  endfunction : pick
  task serve(input int v);
    int n;
    n = 0;
    dly <= 2'($urandom % 4);
    while (grant.valid !== 1'b1 && n < 300)
    begin
      cyc(1);
      n++;
    end
    chk({29'h0, grant.vec_num}, v);
    chk({20'h0, grant.vec_addr}, {20'h0, va[v]});
    while (grant.valid === 1'b1 && n < 600)
    begin
      cyc(1);
      n++;
    end
    chk(32'(core_mode), v == 0 ? 32'(MIC_MODE_NMI) : 32'(MIC_MODE_IRQ));
    pend[v] = 0;
  endtask : serve
  task rti(input mic_mode_t m);
    @(posedge ref_clk);
    ret <= 1;
    @(posedge ref_clk);
    ret <= 0;
    cyc(2);
    chk(32'(core_mode), 32'(m));
  endtask : rti
  task v1_fall;
    @(posedge ref_clk);
    vec1_pin <= 0;
    cyc(2);
    vec1_pin <= 1;
  endtask : v1_fall
  initial
  begin
    #3000000;
    error_cnt++;
    results();
  end
  initial
  begin
    void'($urandom(32'hB9BF0BF0));
    cyc(16);
    nrst <= 1;
    cyc(2);
    chk(32'(core_mode), 32'(MIC_MODE_NMI));
    apb(0, MIC_OPT_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(0, 8'hF0, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1, MIC_PER_EN_OFF, 32'h3);
    // Latch every maskable source while inhibited; second edge dropped
    v1_fall();
    v1_fall();
    @(posedge ref_clk);
    v2 <= 2'h1;
    pf <= 2'h3;
    cyc(2);
    v2 <= 2'h3;
    pend = '{0, 1, 1, 1, 1};
    rti(MIC_MODE_NORMAL);
    cyc(30);
    chk({31'h0, grant.valid}, 32'h0);
    apb(1, MIC_OPT_OFF, 32'h10);
    while (pick(0, 1) > 0)
    begin
      v = pick(0, 1);
      serve(v);
      if (v >= 3)
        pf[v - 3] <= 0;
      rti(MIC_MODE_NORMAL);
    end
    cyc(30);
    chk({31'h0, grant.valid}, 32'h0);
    // NMI pre-empts a maskable routine but never itself
    v1_fall();
    pend[1] = 1;
    serve(1);
    nmi_pin_n <= 0;
    pend[0] = 1;
    serve(0);
    nmi_pin_n <= 1;
    cyc(2);
    nmi_pin_n <= 0;
    cyc(30);
    chk({31'h0, grant.valid}, 32'h0);
    nmi_pin_n <= 1;
    rti(MIC_MODE_IRQ);
    serve(0);
    rti(MIC_MODE_IRQ);
    rti(MIC_MODE_NORMAL);
    // Wake-up from STOP on a pin; NMI cannot wake with enable clear
    stp <= 1;
    v1_fall();
    chk({31'h0, wake}, 32'h1);
    serve(1);
    stp <= 0;
    rti(MIC_MODE_NORMAL);
    apb(1, MIC_OPT_OFF, 32'h0);
    wt <= 1;
    nmi_pin_n <= 0;
    cyc(2);
    chk({31'h0, wake}, 32'h0);
    serve(0);
    wt <= 0;
    nmi_pin_n <= 1;
    rti(MIC_MODE_NORMAL);
    // Level mode on vector 1, with early option clear keeping normal flags
    apb(1, MIC_OPT_OFF, 32'h50);
    @(posedge ref_clk);
    vec1_pin <= 0;
    oce <= 1;
    serve(1);
    chk({31'h0, keep}, 32'h1);
    vec1_pin <= 1;
    oce <= 0;
    rti(MIC_MODE_NORMAL);
    cyc(30);
    chk({31'h0, grant.valid}, 32'h0);
    // Rising polarity switch and pin reconfiguration give spurious vector 2 requests
    apb(1, MIC_OPT_OFF, 32'h30);
    serve(2);
    chk({31'h0, keep}, 32'h0);
    rti(MIC_MODE_NORMAL);
    @(posedge ref_clk);
    v2 <= 2'h2;
    cyc(30);
    chk({31'h0, grant.valid}, 32'h0);
    @(posedge ref_clk);
    v2en <= 2'h2;
    serve(2);
    @(posedge ref_clk);
    v2 <= 2'h3;
    @(posedge ref_clk);
    v2en <= 2'h3;
    rti(MIC_MODE_NORMAL);
    results();
  end
endmodule : mic_ctrl_tb
`default_nettype wire
